/* File: verilog/refbias_consts.svh */
/*
  Constants for the reference and bias enable logic: register address, field positions, resets.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef REFBIAS_CONSTS_SVH
`define REFBIAS_CONSTS_SVH
`define REF_CTRL_ADDR      8'hD1
`define REF_CTRL_RESET     8'h00
`define REF_BIT_BANDGAP    0
`define REF_BIT_OSCBIAS    1
`define REF_CTRL_WMASK     8'h03
`endif

/* File: verilog/refbias_pkg.sv */
/*
  Types shared by the reference and bias enable logic.
  Assumes the constants header is on the include path.
*/
`include "refbias_consts.svh"
package refbias_pkg;
  typedef logic [7:0] sfr_byte_t;
  typedef enum logic {REF_INTERNAL, REF_EXTERNAL} ref_source_e;
endpackage

/* File: verilog/ref_control_reg.sv */
/*
  The 8-bit reference control register on the special function register port.
  Assumes one-cycle write strobes and address from the processor core, same clock.
*/
`timescale 1ns/1ps
`include "refbias_consts.svh"
module ref_control_reg (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic [7:0]            sfrAddr,
  input  wire logic                  sfrWrite,
  input  wire logic [7:0]            sfrWdata,
  output      refbias_pkg::sfr_byte_t ctrlValue,
  output      logic                  addrHit
);
  refbias_pkg::sfr_byte_t next_ctrlValue;

  // ************************************************
  // Register update
  // ************************************************
  always_comb begin
    addrHit = (sfrAddr == `REF_CTRL_ADDR);
    next_ctrlValue = ctrlValue;
    if (sfrWrite && addrHit) begin
      // Upper bits never stored, so they always read back zero
      next_ctrlValue = sfrWdata & `REF_CTRL_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrlValue <= `REF_CTRL_RESET;
    end else begin
      ctrlValue <= next_ctrlValue;
    end
  end

  chk_upper_zero: assert property (@(posedge clk) disable iff (!reset_n)
    ctrlValue[7:2] == 6'h00) else $error("upper control bits not zero");
  chk_reset_clear: assert property (@(posedge clk)
    !reset_n |=> ctrlValue == 8'h00) else $error("control not cleared by reset");
endmodule

/* File: verilog/reference_bias_enable_logic.sv */
/*
  Top of the reference and bias enable logic: register, reference source and generator enables.
  Assumes peripheral enable bits arrive as levels from logic on the same clock.
*/
// Summary of operation
// - Reference select bit chooses internal or external converter reference.
// - Internal reference on only when converter enabled and select bit is zero.
// - Internal reference in use drives its output onto positive reference pin.
// - Oscillator bias on when oscillator enabled or bias force bit one set.
// - Bandgap on when bit 0 force set, converter, second DAC or multiplier enabled.
// - Reference bias comes on automatically for active peripherals, no software write.
// - Control bits seven to two read zero and ignore writes.
// - Bandgap also requested whenever either current-output DAC is enabled.
`timescale 1ns/1ps
`include "refbias_consts.svh"
module reference_bias_enable_logic (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWrite,
  input  wire logic       sfrRead,
  input  wire logic [7:0] sfrWdata,
  output      logic [7:0] sfrRdata,
  output      logic       sfrRdataValid,
  input  wire logic       converterEnableBit,
  input  wire logic       referenceSourceSelect,
  input  wire logic       intOscEnable,
  input  wire logic       firstCurrentDacEnable,
  input  wire logic       secondCurrentDacEnable,
  input  wire logic       clockMultEnable,
  output      logic       internalRefEnable,
  output      logic       refPinDriveInternal,
  output      logic       converterRefExternal,
  output      logic       oscBiasEnable,
  output      logic       bandgapEnable
);
  refbias_pkg::sfr_byte_t ctrlValue;
  logic                   addrHit;
  logic                   oscBiasForceOn;
  logic                   bandgapForceOn;
  refbias_pkg::ref_source_e refSource;
  logic                   next_internalRefEnable;
  logic                   next_refPinDriveInternal;
  logic                   next_converterRefExternal;
  logic                   next_oscBiasEnable;
  logic                   next_bandgapEnable;
  logic [7:0]             next_sfrRdata;
  logic                   next_sfrRdataValid;

  ref_control_reg u_ctrl (
    .clk       (clk),
    .reset_n   (reset_n),
    .sfrAddr   (sfrAddr),
    .sfrWrite  (sfrWrite),
    .sfrWdata  (sfrWdata),
    .ctrlValue (ctrlValue),
    .addrHit   (addrHit)
  );

  // ************************************************
  // Reference source
  // ************************************************
  always_comb begin
    refSource = referenceSourceSelect ? refbias_pkg::REF_EXTERNAL
                                      : refbias_pkg::REF_INTERNAL;
    next_converterRefExternal = (refSource == refbias_pkg::REF_EXTERNAL);
    next_internalRefEnable = converterEnableBit &&
                             (refSource == refbias_pkg::REF_INTERNAL);
    // Pin never driven on its own, so an external source is never fought
    next_refPinDriveInternal = next_internalRefEnable;
  end

  // One cycle of latency is traded for glitch-free enables to the analog side
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      internalRefEnable    <= 1'b0;
      refPinDriveInternal  <= 1'b0;
      converterRefExternal <= 1'b0;
    end else begin
      internalRefEnable    <= next_internalRefEnable;
      refPinDriveInternal  <= next_refPinDriveInternal;
      converterRefExternal <= next_converterRefExternal;
    end
  end

  // ************************************************
  // Generator enables
  // ************************************************
  always_comb begin
    oscBiasForceOn = ctrlValue[`REF_BIT_OSCBIAS];
    bandgapForceOn = ctrlValue[`REF_BIT_BANDGAP];
    next_oscBiasEnable = intOscEnable | oscBiasForceOn;
    // Peripheral terms need no register write, so defaults work from reset
    next_bandgapEnable = bandgapForceOn | converterEnableBit | secondCurrentDacEnable
                       | clockMultEnable | firstCurrentDacEnable;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      oscBiasEnable <= 1'b0;
      bandgapEnable <= 1'b0;
    end else begin
      oscBiasEnable <= next_oscBiasEnable;
      bandgapEnable <= next_bandgapEnable;
    end
  end

  // ************************************************
  // Register read-back
  // ************************************************
  always_comb begin
    next_sfrRdataValid = sfrRead && addrHit;
    // A read in the cycle of a write returns the value held before it
    next_sfrRdata = next_sfrRdataValid ? ctrlValue : 8'h00;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sfrRdata      <= 8'h00;
      sfrRdataValid <= 1'b0;
    end else begin
      sfrRdata      <= next_sfrRdata;
      sfrRdataValid <= next_sfrRdataValid;
    end
  end

  // ************************************************
  // Checks: reference source
  // ************************************************
  // Antecedents carry reset_n, so the edge that releases reset is never judged
  chk_ref_source: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n |=> converterRefExternal == $past(referenceSourceSelect))
    else $error("reference source mismatch");
  chk_ref_select: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n && referenceSourceSelect |=> converterRefExternal)
    else $error("external reference not selected");
  chk_ref_intsel: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n && !referenceSourceSelect |=> !converterRefExternal)
    else $error("external reference wrongly selected");
  chk_ref_exclusive: assert property (@(posedge clk) disable iff (!reset_n)
    !(internalRefEnable && converterRefExternal))
    else $error("internal reference on with external source");
  chk_int_ref: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n && converterEnableBit && !referenceSourceSelect |=> internalRefEnable)
    else $error("internal reference not enabled");
  chk_int_ref_off: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n && (referenceSourceSelect || !converterEnableBit) |=> !internalRefEnable)
    else $error("internal reference wrongly enabled");
  chk_ref_pin: assert property (@(posedge clk) disable iff (!reset_n)
    refPinDriveInternal == internalRefEnable)
    else $error("reference pin not following internal reference");
  chk_ref_pin_on: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n && converterEnableBit && !referenceSourceSelect |=> refPinDriveInternal)
    else $error("reference pin not driven");
  chk_ref_pin_off: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n && (referenceSourceSelect || !converterEnableBit) |=> !refPinDriveInternal)
    else $error("reference pin wrongly driven");

  // ************************************************
  // Checks: generator enables
  // ************************************************
  chk_osc_bias: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n |=> oscBiasEnable == ($past(intOscEnable) || $past(ctrlValue[1])))
    else $error("oscillator bias wrong");
  chk_osc_force: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n && ctrlValue[`REF_BIT_OSCBIAS] |=> oscBiasEnable)
    else $error("oscillator bias force ignored");
  chk_osc_follow: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n && !ctrlValue[`REF_BIT_OSCBIAS] |=> oscBiasEnable == $past(intOscEnable))
    else $error("oscillator bias not following oscillator");
  chk_osc_after_reset: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n && !$past(reset_n) && !intOscEnable |=> !oscBiasEnable)
    else $error("oscillator bias on after reset");
  chk_bandgap: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n && (ctrlValue[0] || converterEnableBit || secondCurrentDacEnable || clockMultEnable)
    |=> bandgapEnable) else $error("bandgap not enabled");
  chk_bandgap_force: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n && ctrlValue[`REF_BIT_BANDGAP] |=> bandgapEnable)
    else $error("bandgap force ignored");
  chk_bandgap_dac1: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n && secondCurrentDacEnable |=> bandgapEnable)
    else $error("bandgap not on for second current DAC");
  chk_bandgap_mult: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n && clockMultEnable |=> bandgapEnable)
    else $error("bandgap not on for clock multiplier");
  chk_bandgap_auto: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n && ctrlValue == 8'h00 && !sfrWrite
    && (firstCurrentDacEnable || converterEnableBit)
    |=> bandgapEnable) else $error("bandgap not automatic");
  chk_bandgap_dac: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n && firstCurrentDacEnable |=> bandgapEnable)
    else $error("bandgap not on for first current DAC");
  chk_bandgap_off: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n && !ctrlValue[0] && !converterEnableBit && !secondCurrentDacEnable
    && !clockMultEnable && !firstCurrentDacEnable |=> !bandgapEnable)
    else $error("bandgap on without cause");
  chk_bg_after_reset: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n && !$past(reset_n) && !converterEnableBit && !secondCurrentDacEnable
    && !clockMultEnable && !firstCurrentDacEnable |=> !bandgapEnable)
    else $error("bandgap on after reset without cause");

  // ************************************************
  // Checks: register
  // ************************************************
  chk_ctrl_write: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n && sfrWrite && sfrAddr == `REF_CTRL_ADDR
    |=> ctrlValue == ($past(sfrWdata) & `REF_CTRL_WMASK)) else $error("control write wrong");
  chk_ctrl_hold: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n && !(sfrWrite && sfrAddr == `REF_CTRL_ADDR) |=> $stable(ctrlValue))
    else $error("control changed without write");
  chk_read_valid: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n |=> sfrRdataValid == ($past(sfrRead) && $past(sfrAddr) == `REF_CTRL_ADDR))
    else $error("read valid wrong");
  chk_read_data: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n && sfrRead && sfrAddr == `REF_CTRL_ADDR |=> sfrRdata == $past(ctrlValue))
    else $error("read data wrong");
  chk_read_other: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n && sfrAddr != `REF_CTRL_ADDR |=> !sfrRdataValid)
    else $error("read of other address answered");
  chk_read_idle: assert property (@(posedge clk) disable iff (!reset_n)
    !sfrRdataValid |-> sfrRdata == 8'h00)
    else $error("read data set without valid");
  chk_read_upper: assert property (@(posedge clk) disable iff (!reset_n)
    sfrRdataValid |-> sfrRdata[7:2] == 6'h00)
    else $error("upper read bits set");
endmodule

/* File: tb/test_reference_bias_enable_logic.sv */
/*
  Self-checking bench for the reference and bias enable logic.
  Assumes the design package and constants header are compiled first.
*/
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin miscompares++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module test_reference_bias_enable_logic;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  sfrAddr = 8'h00;
  logic [7:0]  sfrWdata = 8'h00;
  logic [7:0]  sfrRdata;
  logic        sfrWrite = 1'b0;
  logic        sfrRead = 1'b0;
  logic        sfrRdataValid;
  logic [5:0]  enables = 6'h00;
  logic [4:0]  outs;
  int          miscompares = 0;
  int          compares = 0;
  // Force bits | conv sel osc dac0 dac1 mult | intRef refPin ext osc bandgap
  logic [12:0] rows [10] = '{13'b00_000000_00000, 13'b00_100000_11001, 13'b00_110000_00101,
    13'b00_001000_00010, 13'b00_000100_00001, 13'b00_000010_00001, 13'b00_000001_00001,
    13'b10_000000_00010, 13'b01_000000_00001, 13'b11_010000_00111};

  always #10 clk = ~clk;

  reference_bias_enable_logic u_reference_bias_enable_logic (
    .clk(clk), .reset_n(reset_n), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
    .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
    .sfrRdataValid(sfrRdataValid), .converterEnableBit(enables[5]),
    .referenceSourceSelect(enables[4]), .intOscEnable(enables[3]),
    .firstCurrentDacEnable(enables[2]), .secondCurrentDacEnable(enables[1]),
    .clockMultEnable(enables[0]), .internalRefEnable(outs[4]),
    .refPinDriveInternal(outs[3]), .converterRefExternal(outs[2]),
    .oscBiasEnable(outs[1]), .bandgapEnable(outs[0]));

  // ****************************************
  // Bus cycles and verdict
  // ****************************************
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfrAddr <= a;
    sfrWdata <= d;
    sfrWrite <= 1'b1;
    @(posedge clk);
    sfrWrite <= 1'b0;
  endtask

  task automatic sfr_read(input logic [7:0] a, input logic [7:0] e, input logic v);
    @(posedge clk);
    sfrAddr <= a;
    sfrRead <= 1'b1;
    @(posedge clk);
    sfrRead <= 1'b0;
    #1;
    `CHK("read valid", v, sfrRdataValid)
    `CHK("read data", e, sfrRdata)
  endtask

  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    // Upper bits written as ones so that ignored bits are exercised on every row
    foreach (rows[i]) begin
      sfr_write(8'hD1, {6'h3F, rows[i][12:11]});
      enables <= rows[i][10:5];
      repeat (2) @(posedge clk);
      #1;
      `CHK("enables", rows[i][4:0], outs)
      sfr_read(8'hD1, {6'h00, rows[i][12:11]}, 1'b1);
    end
    $display("test table done");
    sfr_write(8'hD0, 8'h00);
    sfr_read(8'hD0, 8'h00, 1'b0);
    sfr_read(8'hD1, 8'h03, 1'b1);
    $display("test unmapped done");
    // Mid-run reset with both force bits set must drop every generator
    @(posedge clk);
    enables <= 6'h00;
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    `CHK("reset outs", 5'h00, outs)
    sfr_read(8'hD1, 8'h00, 1'b1);
    `CHK("after reset outs", 5'h00, outs)
    $display("test reset done");
    // Read and write in one cycle: the read returns the value held before the write
    @(posedge clk);
    sfrAddr <= 8'hD1;
    sfrWdata <= 8'hFE;
    sfrWrite <= 1'b1;
    sfrRead <= 1'b1;
    @(posedge clk);
    sfrWrite <= 1'b0;
    sfrRead <= 1'b0;
    #1;
    `CHK("same cycle valid", 1'b1, sfrRdataValid)
    `CHK("same cycle read", 8'h00, sfrRdata)
    sfr_read(8'hD1, 8'h02, 1'b1);
    `CHK("osc force outs", 5'h02, outs)
    $display("test same cycle done");
    print_verdict();
  end

  // Run needs about 95 cycles; the limit leaves ample margin
  initial begin
    #40000;
    miscompares++;
    print_verdict();
  end
endmodule
